// >>> hw/acr_map.svh
// Purpose: offsets, field positions, reset values for the channel config bank
// Assumes: page zero of the control port, 8-bit registers
// Notes: definitions only
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

`define ACR_PAGE_CFG 8'h00

`define ACR_OFS_CH2_PHASE 8'h45
`define ACR_OFS_CH3_INPUT 8'h46
`define ACR_OFS_CH3_CHANNEL_GAIN 8'h47
`define ACR_OFS_CH3_VOLUME 8'h48

`define ACR_RST_CH2_PHASE 8'h00
`define ACR_RST_CH3_INPUT 8'h00
`define ACR_RST_CH3_CHANNEL_GAIN 8'h00
`define ACR_RST_CH3_VOLUME 8'hC9

`define ACR_INPUT_KIND_BIT 7
`define ACR_SOURCE_HI 6
`define ACR_SOURCE_LO 5
`define ACR_COUPLING_BIT 4
`define ACR_IMPED_HI 3
`define ACR_IMPED_LO 2
`define ACR_RANGE_EN_BIT 0
`define ACR_GAIN_HI 7
`define ACR_GAIN_LO 2

`define ACR_INPUT_WMASK 8'hFD
`define ACR_GAIN_WMASK 8'hFC

`define ACR_GAIN_MAX 6'h2A
`define ACR_VOL_MUTE 8'h00
`define ACR_VOL_ZERO_DB 9'h0C9

`endif

// >>> hw/acr_pkg.sv
// Purpose: shared types of the channel config bank
// Assumes: nothing beyond the map header
// Notes: encodings follow the register fields
package acr_pkg;

  typedef enum logic [1:0] {
    ACR_SRC_ANALOG_DIFF = 2'h0,
    ACR_SRC_ANALOG_SINGLE = 2'h1,
    ACR_SRC_PULSE_DENSITY = 2'h2,
    ACR_SRC_RESERVED = 2'h3
  } acr_source_t;

  typedef enum logic [1:0] {
    ACR_IMP_LOW = 2'h0,
    ACR_IMP_MEDIUM = 2'h1,
    ACR_IMP_HIGH = 2'h2,
    ACR_IMP_RESERVED = 2'h3
  } acr_impedance_t;

endpackage

// >>> hw/acr_phase_delay.sv
// Purpose: delays a sample stream by a programmed number of modulator ticks
// Assumes: mod_tick is a one-cycle pulse on sys_clk
// Notes: delay zero bypasses the line entirely
`timescale 1ns/1ps
module acr_phase_delay #(
  parameter int SAMPLE_W = 1,
  parameter int DEPTH_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // modulator stream
  input wire logic mod_tick,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [DEPTH_W-1:0] delay,
  output logic [SAMPLE_W-1:0] sample_out_q
);

  localparam int DEPTH = 1 << DEPTH_W;

  logic [DEPTH_W-1:0] wr_ptr_q;
  logic [SAMPLE_W-1:0] mem_q [DEPTH];
  logic [DEPTH_W-1:0] rd_ptr;

  // entry written d ticks ago sits d places behind the write pointer
  assign rd_ptr = wr_ptr_q - delay;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
    end else if (mod_tick) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          mem_q[gi] <= '0;
        end else if (mod_tick && (wr_ptr_q == DEPTH_W'(gi))) begin
          mem_q[gi] <= sample_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sample_out_q <= '0;
    end else if (mod_tick) begin
      if (delay == '0) begin
        sample_out_q <= sample_in;
      end else begin
        sample_out_q <= mem_q[rd_ptr];
      end
    end
  end

endmodule

// >>> hw/acr_config_regs.sv
// Purpose: channel-two phase and channel-three input, gain, volume registers
// Assumes: control-port decoder gives page, address, write and read strobes
// Notes: decoded controls feed the front end, volume path and range logic
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_config_regs
  import acr_pkg::*;
#(
  parameter int SAMPLE_W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control port register access
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // global range or gain selection, bit 3 of the global register
  input wire logic global_range_gain_select_reg,
  // channel-two modulator stream
  input wire logic mod_tick,
  input wire logic [SAMPLE_W-1:0] ch2_sample_in,
  output logic [SAMPLE_W-1:0] ch2_sample_out_q,
  // channel-three pulse-density data pin
  input wire logic pulse_density_data_in_two,
  output logic ch3_pdm_data_q,
  // channel-three front-end controls
  output logic ch3_line_input_q,
  output logic ch3_analog_diff_q,
  output logic ch3_analog_single_q,
  output logic ch3_pdm_select_q,
  output logic ch3_coupling_select_coupled_q,
  output logic [2:0] ch3_impedance_onehot_q,
  output logic ch3_range_enhancer_on_q,
  output logic ch3_channel_gain_control_on_q,
  output logic [5:0] ch3_channel_gain_db_q,
  output logic ch3_mute_q,
  output logic signed [8:0] ch3_volume_half_db_q
);

  logic [7:0] ch2_phase_delay_q;
  logic [7:0] ch3_input_config_q;
  logic [7:0] ch3_channel_gain_config_q;
  logic [7:0] ch3_volume_level_q;

  logic page_hit;
  logic wr_phase;
  logic wr_input;
  logic wr_gain;
  logic wr_volume;
  logic [7:0] rd_mux;

  logic pdm_sync1_q;
  logic pdm_sync2_q;

  logic ch3_input_kind;
  acr_source_t ch3_input_source;
  logic ch3_coupling_select;
  acr_impedance_t ch3_input_impedance;
  logic ch3_range_gain_enable;
  logic [5:0] ch3_channel_gain;
  logic is_analog;

  // address decode
  assign page_hit = (reg_page == `ACR_PAGE_CFG);
  assign wr_phase = reg_wr && page_hit && (reg_addr == `ACR_OFS_CH2_PHASE);
  assign wr_input = reg_wr && page_hit && (reg_addr == `ACR_OFS_CH3_INPUT);
  assign wr_gain = reg_wr && page_hit && (reg_addr == `ACR_OFS_CH3_CHANNEL_GAIN);
  assign wr_volume = reg_wr && page_hit && (reg_addr == `ACR_OFS_CH3_VOLUME);

  // field views
  // input kind bit
  assign ch3_input_kind = ch3_input_config_q[`ACR_INPUT_KIND_BIT];
  assign ch3_input_source = acr_source_t'(ch3_input_config_q[`ACR_SOURCE_HI:`ACR_SOURCE_LO]);
  assign ch3_coupling_select = ch3_input_config_q[`ACR_COUPLING_BIT];
  assign ch3_input_impedance = acr_impedance_t'(ch3_input_config_q[`ACR_IMPED_HI:`ACR_IMPED_LO]);
  assign ch3_range_gain_enable = ch3_input_config_q[`ACR_RANGE_EN_BIT];
  assign ch3_channel_gain = ch3_channel_gain_config_q[`ACR_GAIN_HI:`ACR_GAIN_LO];
  assign is_analog = (ch3_input_source == ACR_SRC_ANALOG_DIFF) ||
                     (ch3_input_source == ACR_SRC_ANALOG_SINGLE);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch2_phase_delay_q <= `ACR_RST_CH2_PHASE;
    end else if (wr_phase) begin
      ch2_phase_delay_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_input_config_q <= `ACR_RST_CH3_INPUT;
    end else if (wr_input) begin
      ch3_input_config_q <= reg_wdata & `ACR_INPUT_WMASK;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_channel_gain_config_q <= `ACR_RST_CH3_CHANNEL_GAIN;
    end else if (wr_gain) begin
      ch3_channel_gain_config_q <= reg_wdata & `ACR_GAIN_WMASK;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_volume_level_q <= `ACR_RST_CH3_VOLUME;
    end else if (wr_volume) begin
      ch3_volume_level_q <= reg_wdata;
    end
  end

  // read path, unmapped or other page reads zero
  always_comb begin
    rd_mux = 8'h00;
    if (page_hit) begin
      unique case (reg_addr)
        `ACR_OFS_CH2_PHASE: rd_mux = ch2_phase_delay_q;
        `ACR_OFS_CH3_INPUT: rd_mux = ch3_input_config_q;
        `ACR_OFS_CH3_CHANNEL_GAIN: rd_mux = ch3_channel_gain_config_q;
        `ACR_OFS_CH3_VOLUME: rd_mux = ch3_volume_level_q;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // valid pulse stands one cycle per read strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
    end
  end

  // data holds until the next read, so a slow host can still fetch it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // channel-two phase calibration line
  // tick-delayed samples
  acr_phase_delay #(
    .SAMPLE_W(SAMPLE_W),
    .DEPTH_W(8)
  ) u_ch2_phase (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .mod_tick(mod_tick),
    .sample_in(ch2_sample_in),
    .delay(ch2_phase_delay_q),
    .sample_out_q(ch2_sample_out_q)
  );

  // pin from outside the clock domain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pdm_sync1_q <= 1'b0;
      pdm_sync2_q <= 1'b0;
    end else begin
      pdm_sync1_q <= pulse_density_data_in_two;
      pdm_sync2_q <= pdm_sync1_q;
    end
  end

  // pin only carries mic data once the host has set it up, so gate by source
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_pdm_data_q <= 1'b0;
    end else begin
      // pdm data only with that source
      ch3_pdm_data_q <= (ch3_input_source == ACR_SRC_PULSE_DENSITY) ? pdm_sync2_q : 1'b0;
    end
  end

  // front-end kind decode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_line_input_q <= 1'b0;
    end else begin
      ch3_line_input_q <= ch3_input_kind;
    end
  end

  // front-end source decode, at most one leg on
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_analog_diff_q <= 1'b0;
      ch3_analog_single_q <= 1'b0;
      ch3_pdm_select_q <= 1'b0;
    end else begin
      ch3_analog_diff_q <= (ch3_input_source == ACR_SRC_ANALOG_DIFF);
      ch3_analog_single_q <= (ch3_input_source == ACR_SRC_ANALOG_SINGLE);
      ch3_pdm_select_q <= (ch3_input_source == ACR_SRC_PULSE_DENSITY);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_coupling_select_coupled_q <= 1'b0;
    end else begin
      ch3_coupling_select_coupled_q <= ch3_coupling_select && is_analog;
    end
  end

  // reserved impedance code leaves all legs off rather than guessing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_impedance_onehot_q <= 3'h0;
    end else begin
      unique case (ch3_input_impedance)
        ACR_IMP_LOW: ch3_impedance_onehot_q <= is_analog ? 3'h1 : 3'h0;
        ACR_IMP_MEDIUM: ch3_impedance_onehot_q <= is_analog ? 3'h2 : 3'h0;
        ACR_IMP_HIGH: ch3_impedance_onehot_q <= is_analog ? 3'h4 : 3'h0;
        ACR_IMP_RESERVED: ch3_impedance_onehot_q <= 3'h0;
      endcase
    end
  end

  // range enhancer while the global select is low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_range_enhancer_on_q <= 1'b0;
    end else begin
      ch3_range_enhancer_on_q <= ch3_range_gain_enable && !global_range_gain_select_reg;
    end
  end

  // gain control while the global select is high, never both at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_channel_gain_control_on_q <= 1'b0;
    end else begin
      ch3_channel_gain_control_on_q <= ch3_range_gain_enable && global_range_gain_select_reg;
    end
  end

  // reserved gain codes are stored but the applied gain is held at the top step
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_channel_gain_db_q <= 6'h00;
    end else begin
      ch3_channel_gain_db_q <= (ch3_channel_gain > `ACR_GAIN_MAX) ? `ACR_GAIN_MAX : ch3_channel_gain;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_mute_q <= 1'b0;
    end else begin
      ch3_mute_q <= (ch3_volume_level_q == `ACR_VOL_MUTE);
    end
  end

  // offset from the 0 dB code, so the scaler downstream needs no compare
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ch3_volume_half_db_q <= 9'sh000;
    end else begin
      ch3_volume_half_db_q <= $signed({1'b0, ch3_volume_level_q} - `ACR_VOL_ZERO_DB);
    end
  end

endmodule

// >>> tb/acr_config_regs_chk.sv
// Purpose: port checker for the channel config bank
// Assumes: one clock, async low reset
// Notes: decoded outputs lag a write by two edges
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_config_regs_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register access
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic global_range_gain_select_reg,
  // decoded controls
  input wire logic ch3_line_input_q,
  input wire logic ch3_pdm_select_q,
  input wire logic ch3_coupling_select_coupled_q,
  input wire logic [2:0] ch3_impedance_onehot_q,
  input wire logic ch3_range_enhancer_on_q,
  input wire logic ch3_channel_gain_control_on_q,
  input wire logic [5:0] ch3_channel_gain_db_q,
  input wire logic ch3_mute_q,
  input wire logic signed [8:0] ch3_volume_half_db_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_in;
    reg_wr && reg_page == 8'h00 && reg_addr == `ACR_OFS_CH3_INPUT;
  endsequence
  property p_kind;
    s_wr_in |=> ##1 ch3_line_input_q == $past(reg_wdata[7], 2);
  endproperty
  property p_src;
    s_wr_in |=> ##1 ch3_pdm_select_q == ($past(reg_wdata[6:5], 2) == 2'h2);
  endproperty
  property p_dc;
    ch3_coupling_select_coupled_q |-> !ch3_pdm_select_q;
  endproperty
  property p_imp;
    $onehot0(ch3_impedance_onehot_q) && !(ch3_pdm_select_q && ch3_impedance_onehot_q != 3'h0);
  endproperty
  property p_range;
    ch3_range_enhancer_on_q |-> !$past(global_range_gain_select_reg);
  endproperty
  property p_gctl;
    ch3_channel_gain_control_on_q |-> $past(global_range_gain_select_reg);
  endproperty
  property p_gain;
    ch3_channel_gain_db_q <= `ACR_GAIN_MAX;
  endproperty
  property p_mute;
    ch3_mute_q |-> ch3_volume_half_db_q == $signed(9'h137);
  endproperty
  property p_resv;
    reg_rd && reg_page == 8'h00 && reg_addr == `ACR_OFS_CH3_CHANNEL_GAIN |=> reg_rdata_q[1:0] == 2'h0;
  endproperty
  a_kind: assert property (p_kind) else $error("input kind wrong");
  a_src: assert property (p_src) else $error("source decode wrong");
  a_dc: assert property (p_dc) else $error("coupling on digital source");
  a_imp: assert property (p_imp) else $error("impedance decode wrong");
  a_range: assert property (p_range) else $error("range enhancer wrong");
  a_gctl: assert property (p_gctl) else $error("gain control wrong");
  a_gain: assert property (p_gain) else $error("gain above limit");
  a_mute: assert property (p_mute) else $error("mute volume wrong");
  a_resv: assert property (p_resv) else $error("reserved bits set");
endmodule

bind acr_config_regs acr_config_regs_chk u_chk (.sys_clk, .nrst, .reg_page, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rd, .reg_rdata_q, .global_range_gain_select_reg, .ch3_line_input_q, .ch3_pdm_select_q, .ch3_coupling_select_coupled_q,
  .ch3_impedance_onehot_q, .ch3_range_enhancer_on_q, .ch3_channel_gain_control_on_q, .ch3_channel_gain_db_q, .ch3_mute_q,
  .ch3_volume_half_db_q);

// >>> tb/acr_config_regs_tb_top.sv
// Purpose: self-checking bench for the channel config bank
// Assumes: page zero decode, one clock
// Notes: model is a register map plus a tick history queue
`timescale 1ns/1ps
module acr_config_regs_tb_top;
  logic sys_clk, nrst, reg_wr, reg_rd, gsel, mod_tick, s_in, pin;
  logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata_q, d;
  logic reg_rvalid_q, s_out, pdm, line, diff, sngl, psel, dc, rng, gctl, mute;
  logic [2:0] imp;
  logic [5:0] gain;
  logic signed [8:0] vol;
  int mismatches, checks_done, m[int], hist[$];
  int gl[5] = '{8'h00, 8'h01, 8'h2A, 8'h2B, 8'h3F};
  int vl[4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};
  int dl[4] = '{8'h01, 8'h00, 8'h03, 8'hFF};
  acr_config_regs u_acr_config_regs (.sys_clk, .nrst, .reg_page, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata_q, .reg_rvalid_q, .global_range_gain_select_reg(gsel), .mod_tick, .ch2_sample_in(s_in),
    .ch2_sample_out_q(s_out), .pulse_density_data_in_two(pin), .ch3_pdm_data_q(pdm), .ch3_line_input_q(line),
    .ch3_analog_diff_q(diff), .ch3_analog_single_q(sngl), .ch3_pdm_select_q(psel), .ch3_coupling_select_coupled_q(dc),
    .ch3_impedance_onehot_q(imp), .ch3_range_enhancer_on_q(rng), .ch3_channel_gain_control_on_q(gctl),
    .ch3_channel_gain_db_q(gain), .ch3_mute_q(mute), .ch3_volume_half_db_q(vol));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] p, logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk) #1;
    reg_page = p;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    // reserved bits masked in the model
    if (p == 8'h00 && m.exists(a)) m[a] = v & (a == 8'h46 ? 8'hFD : a == 8'h47 ? 8'hFC : 8'hFF);
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk) #1;
    reg_page = 8'h00;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    chk("rvalid", reg_rvalid_q, 1);
    chk("rdata", reg_rdata_q, m.exists(a) ? m[a] : 0);
  endtask
  task automatic dec();
    int c, s, z, g;
    repeat (2) @(posedge sys_clk);
    #1;
    c = m[8'h46];
    s = c >> 5 & 3;
    z = c >> 2 & 3;
    g = m[8'h47] >> 2;
    chk("kind", line, c >> 7);
    chk("src", {diff, sngl, psel}, {s == 0, s == 1, s == 2});
    chk("pdm", pdm, s == 2 && pin);
    chk("dc", dc, (c >> 4 & 1) && s < 2);
    chk("imp", imp, (s < 2 && z < 3) ? 1 << z : 0);
    chk("rng", {rng, gctl}, (c & 1) ? (gsel ? 1 : 2) : 0);
    chk("gain", gain, g > 8'h2A ? 8'h2A : g);
    chk("mute", mute, m[8'h48] == 0);
    chk("vol", vol, m[8'h48] - 8'hC9);
  endtask
  task automatic tick(int dd);
    @(posedge sys_clk) #1;
    mod_tick = $urandom;
    s_in = $urandom;
    if (mod_tick) begin
      hist.push_back(s_in);
      @(posedge sys_clk) #1;
      chk("phase", s_out, hist.size() > dd ? hist[hist.size() - 1 - dd] : 0);
      mod_tick = 1'b0;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // hang guard, about seven times the expected run
  initial begin
    #3000000;
    mismatches++;
    test_done();
  end
  initial begin
    {nrst, reg_wr, reg_rd, gsel, mod_tick, s_in, pin} = 7'h00;
    reg_page = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    m[8'h45] = 0;
    m[8'h46] = 0;
    m[8'h47] = 0;
    m[8'h48] = 8'hC9;
    void'($urandom(32'h8cca));
    repeat (5) @(posedge sys_clk);
    #1 nrst = 1'b1;
    for (int a = 8'h44; a < 8'h4A; a++) rd(a);
    wr(8'h01, 8'h48, 8'h00);
    rd(8'h48);
    for (int i = 0; i < 40; i++) begin
      pin = $urandom;
      d = $urandom;
      if (i < 16) d[6:2] = {i[3:2], d[4], i[1:0]};
      wr(8'h00, 8'h46, d);
      wr(8'h00, 8'h47, i < 5 ? gl[i] << 2 | 3 : $urandom);
      wr(8'h00, 8'h48, i < 4 ? vl[i] : $urandom);
      gsel = $urandom;
      dec();
      rd(8'h46);
      rd(8'h47);
      rd(8'h48);
    end
    foreach (dl[k]) begin
      wr(8'h00, 8'h45, dl[k]);
      repeat (600) tick(dl[k]);
    end
    test_done();
  end
endmodule
